//--- verilog/ctec_top.sv
// Operation
// RULE1: With the table zero arm bit set, table zero is engaged once the master phase reaches its engage phase.
// RULE2: With the table one arm bit set, table one is engaged once the master phase reaches its engage phase.
// RULE3: With the table two arm bit set, table two is engaged once the master phase reaches its engage phase.
// RULE4: With the table three arm bit set, table three is engaged once the master phase reaches its engage phase.
// RULE5: Writing 1 to the table zero immediate bit engages table zero at once.
// RULE6: Writing 1 to the table one immediate bit engages table one at once.
// RULE7: Writing 1 to the table two immediate bit engages table two at once.
// RULE8: Writing 1 to the table three immediate bit engages table three at once.
// RULE9: The table zero active flag reads 1 exactly while table zero feeds the profile generator.
// RULE10: The table one active flag reads 1 exactly while table one feeds the profile generator.
// RULE11: The table two active flag reads 1 exactly while table two feeds the profile generator.
// RULE12: The table three active flag reads 1 exactly while table three feeds the profile generator.
// RULE13: Only one table feeds the generator at a time and a new engagement replaces the old one in one step.
// RULE14: Reset clears every arm and immediate bit so nothing is engaged until software sets one.
`timescale 1ns/1ns

// ------------------------------------------------------------------------
// Phase crossing detector
// ------------------------------------------------------------------------
module ctec_phase_cross
    import ctec_pkg::*;
(
    input wire logic [PHASE_W-1:0] phase_i,
    input wire logic [PHASE_W-1:0] prev_phase_i,
    input wire logic [PHASE_W-1:0] level_i,
    output logic hit_o
);

    logic exact;
    logic rising;
    logic wrapped;

    // A cyclic master phase may wrap between samples, so a level that lies
    // in the skipped span past the wrap point is reached as well.
    always_comb begin
        exact = (phase_i == level_i);
        rising = (prev_phase_i < level_i) && (phase_i > level_i);
        wrapped = (prev_phase_i > phase_i) && ((level_i > prev_phase_i) || (level_i < phase_i));
        hit_o = exact || rising || wrapped;
    end

endmodule

// ------------------------------------------------------------------------
// Cam table engagement control
// ------------------------------------------------------------------------
module ctec_top
    import ctec_pkg::*;
(
    input wire logic core_clk_i,
    input wire logic srst_i,
    input wire logic [ADDR_W-1:0] addr_i,
    input wire logic [DATA_W-1:0] wr_data_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [DATA_W-1:0] rd_data_o,
    input wire logic [PHASE_W-1:0] master_phase_i,
    output logic [NUM_TABLES-1:0] active_table_o,
    output logic [1:0] active_index_o,
    output logic active_valid_o,
    output logic engage_pulse_o,
    output logic [PHASE_W-1:0] active_engage_phase_o
);

    logic [NUM_TABLES-1:0] arm;
    logic [NUM_TABLES-1:0] pending;
    logic [NUM_TABLES-1:0] active;
    logic [NUM_TABLES-1:0] phase_hit;
    logic [NUM_TABLES-1:0] arm_hit;
    logic [NUM_TABLES-1:0] imm_req;
    logic [NUM_TABLES-1:0] arm_set;
    logic [NUM_TABLES-1:0] next_active;
    logic [PHASE_W-1:0] engage_phase [NUM_TABLES];
    logic [PHASE_W-1:0] prev_phase;
    logic [PHASE_W-1:0] next_engage_phase;
    logic [COUNT_W-1:0] engage_count;
    logic [1:0] next_index;
    logic phase_valid;
    logic ctrl_wr;
    logic engage;
    ctec_state_t state;
    ctec_state_t next_state;

    // --------------------------------------------------------------------
    // Write decode
    // --------------------------------------------------------------------
    always_comb begin
        ctrl_wr = wr_i && (addr_i == CTRL_OFS);
        imm_req = ctrl_wr ? wr_data_i[IMM_LSB +: NUM_TABLES] : '0;
        arm_set = ctrl_wr ? wr_data_i[ARM_LSB +: NUM_TABLES] : '0;
    end

    // --------------------------------------------------------------------
    // Control word arm bits
    // --------------------------------------------------------------------
    always_ff @(posedge core_clk_i) begin
        if (srst_i) begin
            arm <= ARM_RST; // RULE14
        end else if (ctrl_wr) begin
            arm <= wr_data_i[ARM_LSB +: NUM_TABLES];
        end
    end

    // An armed table engages once per arming; writing the arm bit again
    // re-arms it. A re-arm in the engaging cycle wins over the clear.
    always_ff @(posedge core_clk_i) begin
        if (srst_i) begin
            pending <= ARM_RST; // RULE14
        end else if (ctrl_wr) begin
            pending <= arm_set;
        end else begin
            pending <= pending & ~(engage ? next_active : '0);
        end
    end

    // --------------------------------------------------------------------
    // Engage phase levels
    // --------------------------------------------------------------------
    always_ff @(posedge core_clk_i) begin
        if (srst_i) begin
            for (int i = 0; i < NUM_TABLES; i++) begin
                engage_phase[i] <= PHASE_RST;
            end
        end else if (wr_i) begin
            unique case (addr_i)
                PHASE0_OFS: begin
                    engage_phase[0] <= wr_data_i;
                end
                PHASE1_OFS: begin
                    engage_phase[1] <= wr_data_i;
                end
                PHASE2_OFS: begin
                    engage_phase[2] <= wr_data_i;
                end
                PHASE3_OFS: begin
                    engage_phase[3] <= wr_data_i;
                end
                default: begin
                end
            endcase
        end
    end

    // --------------------------------------------------------------------
    // Master phase history
    // --------------------------------------------------------------------
    // No crossing is judged on the first sample after reset, since the
    // previous phase is not yet known.
    always_ff @(posedge core_clk_i) begin
        if (srst_i) begin
            prev_phase <= PHASE_RST;
            phase_valid <= 1'b0;
        end else begin
            prev_phase <= master_phase_i;
            phase_valid <= 1'b1;
        end
    end

    for (genvar g = 0; g < NUM_TABLES; g++) begin : g_cross
        ctec_phase_cross u_cross (
            .phase_i(master_phase_i),
            .prev_phase_i(prev_phase),
            .level_i(engage_phase[g]),
            .hit_o(phase_hit[g])
        );
    end

    // --------------------------------------------------------------------
    // Engagement selection
    // --------------------------------------------------------------------
    // Immediate requests take precedence over armed crossings; within a
    // group the lowest table number wins.
    always_comb begin
        arm_hit = pending & phase_hit & {NUM_TABLES{phase_valid}};
        engage = 1'b0;
        next_active = active;
        next_index = active_index_o;
        if (imm_req[0]) begin
            engage = 1'b1; // RULE5
            next_active = 4'h1;
            next_index = 2'h0;
        end else if (imm_req[1]) begin
            engage = 1'b1; // RULE6
            next_active = 4'h2;
            next_index = 2'h1;
        end else if (imm_req[2]) begin
            engage = 1'b1; // RULE7
            next_active = 4'h4;
            next_index = 2'h2;
        end else if (imm_req[3]) begin
            engage = 1'b1; // RULE8
            next_active = 4'h8;
            next_index = 2'h3;
        end else if (arm_hit[0]) begin
            engage = 1'b1; // RULE1
            next_active = 4'h1;
            next_index = 2'h0;
        end else if (arm_hit[1]) begin
            engage = 1'b1; // RULE2
            next_active = 4'h2;
            next_index = 2'h1;
        end else if (arm_hit[2]) begin
            engage = 1'b1; // RULE3
            next_active = 4'h4;
            next_index = 2'h2;
        end else if (arm_hit[3]) begin
            engage = 1'b1; // RULE4
            next_active = 4'h8;
            next_index = 2'h3;
        end
        // The reported level is latched at engagement, so a later rewrite of
        // the active table's level register does not show on the output.
        next_engage_phase = engage ? engage_phase[next_index] : active_engage_phase_o;
        next_state = engage ? CTEC_ENGAGED : state;
    end

    // --------------------------------------------------------------------
    // Active table
    // --------------------------------------------------------------------
    // Nothing disengages a table except reset or another engagement: clearing an arm
    // bit only cancels a crossing that has not been seen yet, and an engaged
    // table keeps feeding the generator.
    always_ff @(posedge core_clk_i) begin
        if (srst_i) begin
            active <= ACTIVE_RST;
            state <= CTEC_IDLE;
        end else begin
            active <= next_active; // RULE13
            state <= next_state;
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (srst_i) begin
            active_table_o <= ACTIVE_RST;
            active_index_o <= 2'h0;
            active_valid_o <= 1'b0;
            active_engage_phase_o <= PHASE_RST;
        end else begin
            active_table_o <= next_active; // RULE13
            active_index_o <= next_index;
            active_valid_o <= (next_state == CTEC_ENGAGED);
            active_engage_phase_o <= next_engage_phase;
        end
    end

    // Every engagement pulses once and counts, a repeat engagement of the
    // table that is already active as well. The counter simply wraps.
    always_ff @(posedge core_clk_i) begin
        if (srst_i) begin
            engage_pulse_o <= 1'b0;
            engage_count <= COUNT_RST;
        end else begin
            engage_pulse_o <= engage;
            if (engage) begin
                engage_count <= engage_count + 16'h0001;
            end
        end
    end

    // --------------------------------------------------------------------
    // Read port
    // --------------------------------------------------------------------
    // Immediate bits are write-only actions and read as zero.
    // The active flags read from the active register, which is loaded in step with active_table_o and holds the same value.
    always_ff @(posedge core_clk_i) begin
        if (srst_i) begin
            rd_data_o <= '0;
        end else if (rd_i) begin
            rd_data_o <= '0;
            unique case (addr_i)
                CTRL_OFS: begin
                    rd_data_o[ARM_LSB +: NUM_TABLES] <= arm;
                    rd_data_o[ACT_LSB +: NUM_TABLES] <= active; // RULE9 RULE10 RULE11 RULE12
                end
                PHASE0_OFS: begin
                    rd_data_o <= engage_phase[0];
                end
                PHASE1_OFS: begin
                    rd_data_o <= engage_phase[1];
                end
                PHASE2_OFS: begin
                    rd_data_o <= engage_phase[2];
                end
                PHASE3_OFS: begin
                    rd_data_o <= engage_phase[3];
                end
                STATUS_OFS: begin
                    rd_data_o[ST_PEND_LSB +: NUM_TABLES] <= pending;
                    rd_data_o[ST_IDX_LSB +: 2] <= active_index_o;
                    rd_data_o[ST_VALID_BIT] <= (state == CTEC_ENGAGED);
                    rd_data_o[ST_COUNT_LSB +: COUNT_W] <= engage_count;
                end
                MASTER_OFS: begin
                    rd_data_o <= master_phase_i;
                end
                default: begin
                end
            endcase
        end
    end

endmodule

//--- verilog/ctec_pkg.sv
package ctec_pkg;

    // --------------------------------------------------------------------
    // Sizes
    // --------------------------------------------------------------------
    localparam int unsigned NUM_TABLES = 4;
    localparam int unsigned PHASE_W = 32;
    localparam int unsigned DATA_W = 32;
    localparam int unsigned ADDR_W = 8;
    localparam int unsigned CTRL_W = 16;
    localparam int unsigned COUNT_W = 16;

    // --------------------------------------------------------------------
    // Register offsets (byte addresses)
    // --------------------------------------------------------------------
    localparam logic [ADDR_W-1:0] CTRL_OFS = 8'h00;
    localparam logic [ADDR_W-1:0] PHASE0_OFS = 8'h04;
    localparam logic [ADDR_W-1:0] PHASE1_OFS = 8'h08;
    localparam logic [ADDR_W-1:0] PHASE2_OFS = 8'h0c;
    localparam logic [ADDR_W-1:0] PHASE3_OFS = 8'h10;
    localparam logic [ADDR_W-1:0] STATUS_OFS = 8'h14;
    localparam logic [ADDR_W-1:0] MASTER_OFS = 8'h18;

    // --------------------------------------------------------------------
    // Field positions of the control word
    // --------------------------------------------------------------------
    localparam int unsigned ARM_LSB = 0;
    localparam int unsigned IMM_LSB = 4;
    localparam int unsigned ACT_LSB = 8;

    // --------------------------------------------------------------------
    // Field positions of the status register
    // --------------------------------------------------------------------
    localparam int unsigned ST_PEND_LSB = 0;
    localparam int unsigned ST_IDX_LSB = 4;
    localparam int unsigned ST_VALID_BIT = 6;
    localparam int unsigned ST_COUNT_LSB = 16;

    // --------------------------------------------------------------------
    // Reset values
    // --------------------------------------------------------------------
    localparam logic [NUM_TABLES-1:0] ARM_RST = 4'h0;
    localparam logic [NUM_TABLES-1:0] ACTIVE_RST = 4'h0;
    localparam logic [PHASE_W-1:0] PHASE_RST = 32'h0000_0000;
    localparam logic [COUNT_W-1:0] COUNT_RST = 16'h0000;

    // --------------------------------------------------------------------
    // Engagement state
    // --------------------------------------------------------------------
    typedef enum logic [1:0] {
        CTEC_IDLE = 2'b01,
        CTEC_ENGAGED = 2'b10
    } ctec_state_t;

endpackage

//--- tb/ctec_phase_model.sv
`timescale 1ns/1ns
// ------------------------------------------------------------------------
// Master axis phase source
// ------------------------------------------------------------------------
module ctec_phase_model
    import ctec_pkg::*;
(
    input wire logic core_clk_i,
    input wire logic srst_i,
    input wire logic run_i,
    input wire logic load_i,
    input wire logic [PHASE_W-1:0] start_i,
    input wire logic [PHASE_W-1:0] step_i,
    output logic [PHASE_W-1:0] phase_o
);
    // The phase advances by step_i per cycle while running and wraps like the real axis.
    always @(posedge core_clk_i) begin
        if (srst_i) begin
            phase_o <= 32'h0;
        end else if (load_i) begin
            phase_o <= start_i;
        end else if (run_i) begin
            phase_o <= phase_o + step_i;
        end
    end
endmodule

//--- tb/ctec_top_checker.sv
`timescale 1ns/1ns
// ------------------------------------------------------------------------
// Port checker
// ------------------------------------------------------------------------
module ctec_top_checker
    import ctec_pkg::*;
(
    input wire logic core_clk_i,
    input wire logic srst_i,
    input wire logic [ADDR_W-1:0] addr_i,
    input wire logic [DATA_W-1:0] wr_data_i,
    input wire logic wr_i,
    input wire logic rd_i,
    input wire logic [DATA_W-1:0] rd_data_o,
    input wire logic [NUM_TABLES-1:0] active_table_o,
    input wire logic [1:0] active_index_o,
    input wire logic active_valid_o,
    input wire logic engage_pulse_o
);
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (srst_i);
    logic [3:0] imm_low;
    assign imm_low = wr_data_i[7:4] & (~wr_data_i[7:4] + 4'h1);

    chk_imm_engage: assert property (wr_i && addr_i == CTRL_OFS && imm_low != 4'h0
        |=> engage_pulse_o && active_table_o == $past(imm_low)) else $error("immediate engage missed");
    chk_one_table: assert property (active_valid_o |-> $onehot(active_table_o))
        else $error("active flags not one-hot");
    chk_flag_index: assert property (active_valid_o |-> active_table_o == (4'h1 << active_index_o))
        else $error("active flag and index disagree");
    chk_reset_clear: assert property ($past(srst_i) |-> active_table_o == 4'h0 && !active_valid_o)
        else $error("engaged after reset");
    chk_hold_quiet: assert property (!engage_pulse_o |-> $stable(active_table_o) && $stable(active_index_o))
        else $error("active table changed without engagement");
    chk_valid_sticky: assert property (active_valid_o |=> active_valid_o)
        else $error("engagement dropped");
    chk_read_flags: assert property (rd_i && addr_i == CTRL_OFS
        |=> rd_data_o[11:8] == $past(active_table_o) && rd_data_o[7:4] == 4'h0) else $error("control read wrong");
    chk_unmapped_zero: assert property (rd_i && addr_i[7:5] != 3'h0 |=> rd_data_o == 32'h0)
        else $error("unmapped read not zero");
endmodule

bind ctec_top ctec_top_checker chk_u (
    .core_clk_i(core_clk_i),
    .srst_i(srst_i),
    .addr_i(addr_i),
    .wr_data_i(wr_data_i),
    .wr_i(wr_i),
    .rd_i(rd_i),
    .rd_data_o(rd_data_o),
    .active_table_o(active_table_o),
    .active_index_o(active_index_o),
    .active_valid_o(active_valid_o),
    .engage_pulse_o(engage_pulse_o)
);

//--- tb/cam_table_engagement_control_test.sv
`timescale 1ns/1ns
module cam_table_engagement_control_test
    import ctec_pkg::*;
;
    logic core_clk_i = 1'h0;
    logic srst_i = 1'h1;
    logic [ADDR_W-1:0] addr_i = 8'h0;
    logic [DATA_W-1:0] wr_data_i = 32'h0;
    logic wr_i = 1'h0;
    logic rd_i = 1'h0;
    logic [DATA_W-1:0] rd_data_o;
    logic [PHASE_W-1:0] master_phase_i;
    logic [NUM_TABLES-1:0] active_table_o;
    logic [1:0] active_index_o;
    logic active_valid_o;
    logic engage_pulse_o;
    logic [PHASE_W-1:0] active_engage_phase_o;
    logic run = 1'h0;
    logic load = 1'h0;
    logic [PHASE_W-1:0] start = 32'h0;
    logic [PHASE_W-1:0] step = 32'h0;
    int err_count = 0;
    int n_compared = 0;

    always #2 core_clk_i = ~core_clk_i;

    ctec_top dut_u (.core_clk_i(core_clk_i), .srst_i(srst_i), .addr_i(addr_i), .wr_data_i(wr_data_i),
        .wr_i(wr_i), .rd_i(rd_i), .rd_data_o(rd_data_o), .master_phase_i(master_phase_i),
        .active_table_o(active_table_o), .active_index_o(active_index_o), .active_valid_o(active_valid_o),
        .engage_pulse_o(engage_pulse_o), .active_engage_phase_o(active_engage_phase_o));
    ctec_phase_model model_u (.core_clk_i(core_clk_i), .srst_i(srst_i), .run_i(run), .load_i(load),
        .start_i(start), .step_i(step), .phase_o(master_phase_i));

    // --------------------------------------------------------------------
    // Shared tasks
    // --------------------------------------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
        n_compared++;
        if (seen !== exp) begin
            err_count++;
            $display("MISMATCH t=%0t %s seen %h expected %h", $time, msg, seen, exp);
        end
    endtask

    task automatic bus_wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk_i);
        wr_i <= 1'h1;
        addr_i <= a;
        wr_data_i <= d;
        @(posedge core_clk_i);
        wr_i <= 1'h0;
        #1;
    endtask

    task automatic bus_rd(input logic [7:0] a, input logic [31:0] exp, input string msg);
        @(posedge core_clk_i);
        rd_i <= 1'h1;
        addr_i <= a;
        @(posedge core_clk_i);
        rd_i <= 1'h0;
        #1;
        check(rd_data_o, exp, msg);
    endtask

    task automatic report_and_stop();
        $display("Compared %0d, mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // --------------------------------------------------------------------
    // Scenarios
    // --------------------------------------------------------------------
    task automatic test_reset();
        check({24'h0, active_table_o, 3'h0, active_valid_o}, 32'h0, "engaged after reset");
        bus_rd(CTRL_OFS, 32'h0, "control after reset");
        bus_wr(8'h40, 32'hf0);
        bus_rd(8'h40, 32'h0, "unmapped read");
        check({28'h0, active_table_o}, 32'h0, "unmapped write engaged");
        $display("test_reset done");
    endtask

    task automatic test_immediate();
        for (int i = 0; i < 4; i++) begin
            bus_wr(CTRL_OFS, 32'h10 << i);
            check({27'h0, active_valid_o, active_table_o}, 32'h10 | (32'h1 << i), "immediate table");
            check({29'h0, active_index_o, engage_pulse_o}, (i << 1) | 1, "index or pulse");
            bus_rd(CTRL_OFS, 32'h100 << i, "active flag read");
        end
        // Two immediate bits in one write: the lower table wins.
        bus_wr(CTRL_OFS, 32'ha0);
        check({28'h0, active_table_o}, 32'h2, "immediate priority");
        $display("test_immediate done");
    endtask

    task automatic test_armed();
        logic [31:0] lvl;
        logic [31:0] pk;
        int n;
        for (int i = 0; i < 4; i++) begin
            lvl = (i == 3) ? 32'h10 : 32'h100 + 32'(i);
            start <= (i == 3) ? 32'hffff_ff00 : 32'h0;
            step <= (i == 0) ? 32'h1 : 32'h30;
            load <= 1'h1;
            bus_wr(PHASE0_OFS + 8'(4 * i), lvl);
            load <= 1'h0;
            bus_wr(CTRL_OFS, 32'h1 << i);
            repeat (3) @(posedge core_clk_i);
            #1;
            check({28'h0, active_table_o}, (i == 0) ? 32'h2 : 32'h1 << (i - 1), "engaged early");
            pk = start + step * ((lvl - start + step - 32'h1) / step);
            run <= 1'h1;
            n = 0;
            while (engage_pulse_o !== 1'h1 && n < 2000) begin
                @(posedge core_clk_i);
                #1;
                n++;
            end
            run <= 1'h0;
            check({28'h0, active_table_o}, 32'h1 << i, "armed table");
            check(master_phase_i - step, pk, "engage moment");
            check(active_engage_phase_o, lvl, "engage level");
        end
        $display("test_armed done");
    endtask

    task automatic test_status_reset();
        bus_wr(PHASE3_OFS, 32'h1234_5678);
        check(active_engage_phase_o, 32'h10, "engage level held");
        bus_rd(PHASE3_OFS, 32'h1234_5678, "level read back");
        bus_rd(MASTER_OFS, master_phase_i, "master phase read");
        bus_rd(STATUS_OFS, (32'h9 << ST_COUNT_LSB) | (32'h1 << ST_VALID_BIT) | (32'h3 << ST_IDX_LSB), "status");
        bus_wr(CTRL_OFS, 32'h1);
        bus_rd(CTRL_OFS, 32'h801, "armed before reset");
        @(posedge core_clk_i);
        srst_i <= 1'h1;
        repeat (2) @(posedge core_clk_i);
        srst_i <= 1'h0;
        @(posedge core_clk_i);
        #1;
        check({24'h0, active_table_o, 3'h0, active_valid_o}, 32'h0, "engaged after second reset");
        check(active_engage_phase_o, 32'h0, "level after second reset");
        bus_rd(CTRL_OFS, 32'h0, "control after second reset");
        bus_rd(STATUS_OFS, 32'h0, "status after second reset");
        $display("test_status_reset done");
    endtask

    initial begin
        repeat (6) @(posedge core_clk_i);
        srst_i <= 1'h0;
        @(posedge core_clk_i);
        #1;
        test_reset();
        test_immediate();
        test_armed();
        test_status_reset();
        report_and_stop();
    end

    initial begin
        repeat (20000) @(posedge core_clk_i);
        err_count++;
        report_and_stop();
    end
endmodule
